// File: rtl/ccpcm_top.sv
// Two compare units with AXI4-Lite registers, timer and interrupt
// Function
// - Compare value continuously checked against timer count; equal means match while mode bit 3 is set.
// - On match pin goes high, low or stays, per four-bit mode field.
// - Every match sets compare match flag with the pin action.
// - Clearing the whole control register forces output latch low.
// - Software interrupt mode leaves pin untouched, only raises flag.
// - First unit special trigger clears timer, giving a period register.
// - Second unit trigger clears timer and starts conversion if enabled.
// - On the variant, first unit trigger also starts conversion.
// - Trigger-caused timer clear never sets the overflow flag.
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module ccpcm_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic tmr_tick_i,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pin1_o,
  output logic pin2_o,
  output logic adc_start_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0] mode1_q;
  logic [3:0] mode2_q;
  logic [15:0] val1_q;
  logic [15:0] val2_q;
  logic [3:0] stat_q;
  logic [3:0] stat_d;
  logic [3:0] mask_q;
  logic [1:0] misc_q;
  logic adc_q;
  logic [7:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ----------------------------------------------------------------
  // Units and timer
  // ----------------------------------------------------------------
  ccpcm_pkg::ccpcm_evt_t evt1_w;
  ccpcm_pkg::ccpcm_evt_t evt2_w;
  logic [15:0] count_w;
  logic ovf_w;
  logic trig_w;
  logic adc_go_w;

  ccpcm_unit u_unit1 (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_i(mode1_q),
    .value_i(val1_q), .count_i(count_w), .pin_o(pin1_o), .evt_o(evt1_w)
  );
  ccpcm_unit u_unit2 (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_i(mode2_q),
    .value_i(val2_q), .count_i(count_w), .pin_o(pin2_o), .evt_o(evt2_w)
  );

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic do_wr_w;
  logic wr_ok_w;
  logic wr_ctrl1_w;
  logic wr_ctrl2_w;
  logic wr_val1_w;
  logic wr_val2_w;
  logic wr_stat_w;
  logic wr_mask_w;
  logic wr_tmr_w;
  logic wr_misc_w;
  logic [3:0] w1c_w;

  assign do_wr_w = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ctrl1_w = do_wr_w && awaddr_q == ccpcm_pkg::ADDR_CTRL1;
  assign wr_ctrl2_w = do_wr_w && awaddr_q == ccpcm_pkg::ADDR_CTRL2;
  assign wr_val1_w = do_wr_w && awaddr_q == ccpcm_pkg::ADDR_VAL1;
  assign wr_val2_w = do_wr_w && awaddr_q == ccpcm_pkg::ADDR_VAL2;
  assign wr_stat_w = do_wr_w && awaddr_q == ccpcm_pkg::ADDR_STAT;
  assign wr_mask_w = do_wr_w && awaddr_q == ccpcm_pkg::ADDR_MASK;
  assign wr_tmr_w = do_wr_w && awaddr_q == ccpcm_pkg::ADDR_TMR;
  assign wr_misc_w = do_wr_w && awaddr_q == ccpcm_pkg::ADDR_MISC;
  assign wr_ok_w = wr_ctrl1_w | wr_ctrl2_w | wr_val1_w | wr_val2_w |
    wr_stat_w | wr_mask_w | wr_tmr_w | wr_misc_w;
  assign w1c_w = (wr_stat_w && wstrb_q[0]) ? wdata_q[3:0] : 4'h0;

  // A trigger and a software load in one cycle: software wins
  assign trig_w = evt1_w.trig | evt2_w.trig;
  assign adc_go_w = misc_q[ccpcm_pkg::MISC_ADON] && (evt2_w.trig ||
    (evt1_w.trig && misc_q[ccpcm_pkg::MISC_VARIANT]));

  ccpcm_timer u_timer (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tick_i(tmr_tick_i),
    .clear_i(trig_w), .load_i(wr_tmr_w && wstrb_q[1:0] == 2'h3),
    .load_val_i(wdata_q[15:0]), .count_o(count_w), .ovf_o(ovf_w)
  );

  // ----------------------------------------------------------------
  // Status: hardware set wins over write-one-clear
  // ----------------------------------------------------------------
  logic [3:0] set_w;
  assign set_w = {trig_w, ovf_w, evt2_w.match, evt1_w.match};
  assign stat_d = (stat_q & ~w1c_w) | set_w;
  assign irq_o = |(stat_q & mask_q);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stat_q <= 4'h0;
      mask_q <= 4'h0;
      adc_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      adc_q <= adc_go_w;
      if (wr_mask_w && wstrb_q[0]) begin
        mask_q <= wdata_q[3:0];
      end
    end
  end
  assign adc_start_o = adc_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode1_q <= ccpcm_pkg::CTRL_RST;
      mode2_q <= ccpcm_pkg::CTRL_RST;
      val1_q <= ccpcm_pkg::VAL_RST;
      val2_q <= ccpcm_pkg::VAL_RST;
      misc_q <= 2'h0;
    end else begin
      if (wr_ctrl1_w && wstrb_q[0]) begin
        mode1_q <= wdata_q[3:0];
      end
      if (wr_ctrl2_w && wstrb_q[0]) begin
        mode2_q <= wdata_q[3:0];
      end
      if (wr_val1_w) begin
        if (wstrb_q[0]) val1_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) val1_q[15:8] <= wdata_q[15:8];
      end
      if (wr_val2_w) begin
        if (wstrb_q[0]) val2_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) val2_q[15:8] <= wdata_q[15:8];
      end
      if (wr_misc_w && wstrb_q[0]) begin
        misc_q <= wdata_q[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data may come in either order; both held until B
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= ccpcm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr_w) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok_w ? ccpcm_pkg::RESP_OKAY : ccpcm_pkg::RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Unmapped offsets answer SLVERR with zero data
  logic [7:0] ra_w;
  logic [31:0] rmux_w;
  logic rhit_w;
  assign ra_w = s_axi_araddr[7:0];
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    rmux_w = 32'h00000000;
    rhit_w = 1'b1;
    unique case (ra_w)
      ccpcm_pkg::ADDR_CTRL1: rmux_w = {28'h0000000, mode1_q};
      ccpcm_pkg::ADDR_VAL1: rmux_w = {16'h0000, val1_q};
      ccpcm_pkg::ADDR_CTRL2: rmux_w = {28'h0000000, mode2_q};
      ccpcm_pkg::ADDR_VAL2: rmux_w = {16'h0000, val2_q};
      ccpcm_pkg::ADDR_STAT: rmux_w = {28'h0000000, stat_q};
      ccpcm_pkg::ADDR_MASK: rmux_w = {28'h0000000, mask_q};
      ccpcm_pkg::ADDR_TMR: rmux_w = {16'h0000, count_w};
      ccpcm_pkg::ADDR_MISC: rmux_w = {30'h0, misc_q};
      default: rhit_w = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= ccpcm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rmux_w;
      rresp_q <= rhit_w ? ccpcm_pkg::RESP_OKAY : ccpcm_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_match_flag: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    evt1_w.match |=> stat_q[ccpcm_pkg::ST_MATCH1])
    else $error("match flag not set");
  chk_match2_flag: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    evt2_w.match |=> stat_q[ccpcm_pkg::ST_MATCH2])
    else $error("second match flag not set");
  chk_trig_clear: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    trig_w && !(wr_tmr_w && wstrb_q[1:0] == 2'h3) |=> count_w == 16'h0000)
    else $error("trigger did not clear timer");
  chk_adc_start: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    evt2_w.trig && misc_q[ccpcm_pkg::MISC_ADON] |=> adc_start_o)
    else $error("no conversion start from second unit");
  chk_adc_variant: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    evt1_w.trig && !evt2_w.trig && !misc_q[ccpcm_pkg::MISC_VARIANT]
    |=> !adc_start_o)
    else $error("first unit started conversion off variant");
  chk_no_ovf: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    trig_w |-> !ovf_w)
    else $error("trigger raised overflow");
  chk_ovf_flag: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    ovf_w |=> stat_q[ccpcm_pkg::ST_TOVF])
    else $error("overflow flag not set on wrap");
  // An enabled event must raise the line unless the mask is being rewritten
  chk_irq_level: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    |(set_w & mask_q) && !wr_mask_w |=> irq_o)
    else $error("interrupt not raised for enabled event");
  cov_pin_hi: cover property (@(posedge clk_i) $rose(pin1_o));
  cov_trig: cover property (@(posedge clk_i) trig_w);
  cov_adc: cover property (@(posedge clk_i) adc_start_o);
  cov_irq: cover property (@(posedge clk_i) $rose(irq_o));

endmodule : ccpcm_top
`default_nettype wire

// File: inc/ccpcm_pkg.sv
// Package: register map, field layout, mode codes and carrier types
package ccpcm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_VAL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_VAL2 = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_TMR = 8'h18;
  localparam logic [7:0] ADDR_MISC = 8'h1C;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int MODE_W = 4;
  localparam int STAT_W = 4;
  localparam int ST_MATCH1 = 0;
  localparam int ST_MATCH2 = 1;
  localparam int ST_TOVF = 2;
  localparam int ST_TRIG = 3;
  localparam int MISC_ADON = 0;
  localparam int MISC_VARIANT = 1;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] VAL_RST = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Compare mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_SET_HI = 4'h8;
  localparam logic [3:0] MODE_SET_LO = 4'h9;
  localparam logic [3:0] MODE_SWINT = 4'hA;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;

  // Per-unit events toward the top
  typedef struct packed {
    logic match;
    logic trig;
  } ccpcm_evt_t;

endpackage : ccpcm_pkg

// File: rtl/ccpcm_unit.sv
// One compare unit: match detect, output latch and event trigger
`timescale 1ns/100ps
`default_nettype none
module ccpcm_unit (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] mode_i,
  input wire logic [15:0] value_i,
  input wire logic [15:0] count_i,
  output var logic pin_o,
  output var ccpcm_pkg::ccpcm_evt_t evt_o
);

  logic pin_q;
  logic pin_d;
  logic eq_w;
  logic armed_w;
  logic hit_w;
  logic trig_w;

  assign eq_w = (value_i == count_i);
  assign armed_w = mode_i[3];
  assign hit_w = eq_w && armed_w;

  always_comb begin
    pin_d = pin_q;
    if (mode_i == ccpcm_pkg::MODE_OFF) begin
      pin_d = 1'b0;
    end else if (hit_w && mode_i == ccpcm_pkg::MODE_SET_HI) begin
      pin_d = 1'b1;
    end else if (hit_w && mode_i == ccpcm_pkg::MODE_SET_LO) begin
      pin_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign pin_o = pin_q;
  assign trig_w = hit_w && mode_i == ccpcm_pkg::MODE_SPECIAL;
  // Match pulse lands with the pin update edge
  assign evt_o = '{match: hit_w, trig: trig_w};

  chk_pin_high: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    hit_w && mode_i == ccpcm_pkg::MODE_SET_HI |=> pin_q)
    else $error("pin not driven high on match");
  chk_pin_low: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    hit_w && mode_i == ccpcm_pkg::MODE_SET_LO |=> !pin_q)
    else $error("pin not driven low on match");
  chk_swint_keep: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    mode_i == ccpcm_pkg::MODE_SWINT |=> pin_q == $past(pin_q))
    else $error("pin changed in software interrupt mode");
  chk_off_low: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    mode_i == ccpcm_pkg::MODE_OFF |=> !pin_q)
    else $error("latch not low with control cleared");
  chk_match_eq: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    evt_o.match |-> value_i == count_i)
    else $error("match without equal count");

endmodule : ccpcm_unit
`default_nettype wire

// File: rtl/ccpcm_timer.sv
// Timer-one count with special event clear
`timescale 1ns/100ps
`default_nettype none
module ccpcm_timer (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [15:0] load_val_i,
  output var logic [15:0] count_o,
  output var logic ovf_o
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic wrap_w;

  assign wrap_w = tick_i && (cnt_q == 16'hFFFF) && !clear_i;

  always_comb begin
    cnt_d = cnt_q;
    if (load_i) begin
      cnt_d = load_val_i;
    end else if (clear_i) begin
      cnt_d = 16'h0000;
    end else if (tick_i) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count_o = cnt_q;
  // Only a real wrap counts as overflow, never a trigger clear
  assign ovf_o = wrap_w && !load_i;

endmodule : ccpcm_timer
`default_nettype wire

// File: bench/ccpcm_far_model.sv
// Far-side model: timer-one tick source and converter start counter
`timescale 1ns/100ps
`default_nettype none
module ccpcm_far_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic slow_i,
  input wire logic adc_start_i,
  output logic tick_o,
  output var logic [15:0] conv_count_o
);
  logic phase_q;
  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  // Ticks stay in the system clock domain, as a synchronized counter
  assign tick_o = run_i & (~slow_i | phase_q);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phase_q <= 1'b0;
      conv_count_o <= 16'h0000;
    end else begin
      phase_q <= ~phase_q;
      if (adc_start_i) begin
        conv_count_o <= conv_count_o + 16'h0001;
      end
    end
  end
endmodule : ccpcm_far_model
`default_nettype wire

// File: bench/ccpcm_top_tb_top.sv
// Testbench for the compare block over its register bus
`timescale 1ns/100ps
`default_nettype none
module ccpcm_top_tb_top;
  logic clk_i, sys_rst_i, run, slow, tick, pin1, pin2, adc, irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] conv;
  logic [31:0] rd;
  logic [15:0] base;
  int err_total, check_count, cyc;

  ccpcm_top ccpcm_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .tmr_tick_i(tick), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin1_o(pin1), .pin2_o(pin2),
    .adc_start_o(adc), .irq_o(irq));

  ccpcm_far_model ccpcm_far_model_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .run_i(run), .slow_i(slow),
    .adc_start_i(adc), .tick_o(tick), .conv_count_o(conv));

  // ----------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    awaddr <= {24'h000000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_i);
    araddr <= {24'h000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  // Restart the count from a known value and let it run a while
  task automatic run_timer(input logic [15:0] start, input logic slw);
    wr(ccpcm_pkg::ADDR_TMR, {16'h0000, start});
    wr(ccpcm_pkg::ADDR_STAT, 32'h0000000F);
    @(posedge clk_i);
    run <= 1'b1;
    slow <= slw;
    repeat (40) @(posedge clk_i);
    run <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : run_timer

  task automatic finish_test;
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready, run, slow} = '0;
    err_total = 0;
    check_count = 0;
    cyc = 0;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_reg(ccpcm_pkg::ADDR_VAL1);
    check(rd, {16'h0000, ccpcm_pkg::VAL_RST});
    rd_reg(8'h20);
    check({30'h0, rsp}, {30'h0, ccpcm_pkg::RESP_SLVERR});
    wr(8'h20, 32'h0000000F);
    check({30'h0, rsp}, {30'h0, ccpcm_pkg::RESP_SLVERR});
    // Drive-high on both units
    wr(ccpcm_pkg::ADDR_CTRL1, {28'h0, ccpcm_pkg::MODE_SET_HI});
    check({30'h0, rsp}, {30'h0, ccpcm_pkg::RESP_OKAY});
    wr(ccpcm_pkg::ADDR_CTRL2, {28'h0, ccpcm_pkg::MODE_SET_HI});
    wr(ccpcm_pkg::ADDR_VAL1, 32'h00000010);
    wr(ccpcm_pkg::ADDR_VAL2, 32'h00000020);
    run_timer(16'h0000, 1'b0);
    check({30'h0, pin2, pin1}, 32'h00000003);
    rd_reg(ccpcm_pkg::ADDR_STAT);
    check(rd, 32'h00000003);
    // Drive-low on unit 1, software interrupt on unit 2
    wr(ccpcm_pkg::ADDR_CTRL1, {28'h0, ccpcm_pkg::MODE_SET_LO});
    wr(ccpcm_pkg::ADDR_CTRL2, {28'h0, ccpcm_pkg::MODE_SWINT});
    run_timer(16'h0000, 1'b0);
    check({30'h0, pin2, pin1}, 32'h00000002);
    rd_reg(ccpcm_pkg::ADDR_STAT);
    check(rd, 32'h00000003);
    // Clearing the control register drops the latch
    wr(ccpcm_pkg::ADDR_CTRL2, 32'h00000000);
    @(posedge clk_i);
    check({31'h0, pin2}, 32'h00000000);
    // Interrupt: masked, raised, cleared
    check({31'h0, irq}, 32'h00000000);
    wr(ccpcm_pkg::ADDR_MASK, 32'h00000002);
    check({31'h0, irq}, 32'h00000001);
    wr(ccpcm_pkg::ADDR_STAT, 32'h00000002);
    @(posedge clk_i);
    check({31'h0, irq}, 32'h00000000);
    // Unit 1 special trigger as a period, slow ticks, variant off
    wr(ccpcm_pkg::ADDR_CTRL1, {28'h0, ccpcm_pkg::MODE_SPECIAL});
    wr(ccpcm_pkg::ADDR_VAL1, 32'h00000005);
    wr(ccpcm_pkg::ADDR_MISC, 32'h00000001);
    base = conv;
    run_timer(16'h0000, 1'b1);
    rd_reg(ccpcm_pkg::ADDR_TMR);
    check({31'h0, rd[15:0] <= 16'h0005}, 32'h00000001);
    rd_reg(ccpcm_pkg::ADDR_STAT);
    check(rd, 32'h00000009);
    check({16'h0, conv - base}, 32'h00000000);
    // Variant: unit 1 trigger also starts conversions
    wr(ccpcm_pkg::ADDR_MISC, 32'h00000003);
    base = conv;
    run_timer(16'h0000, 1'b0);
    check({31'h0, conv != base}, 32'h00000001);
    // Unit 2 trigger with converter on, then off
    wr(ccpcm_pkg::ADDR_CTRL1, 32'h00000000);
    wr(ccpcm_pkg::ADDR_CTRL2, {28'h0, ccpcm_pkg::MODE_SPECIAL});
    wr(ccpcm_pkg::ADDR_VAL2, 32'h00000007);
    wr(ccpcm_pkg::ADDR_MISC, 32'h00000001);
    base = conv;
    run_timer(16'h0000, 1'b0);
    check({31'h0, conv != base}, 32'h00000001);
    rd_reg(ccpcm_pkg::ADDR_TMR);
    check({31'h0, rd[15:0] <= 16'h0007}, 32'h00000001);
    wr(ccpcm_pkg::ADDR_MISC, 32'h00000000);
    base = conv;
    run_timer(16'h0000, 1'b0);
    check({16'h0, conv - base}, 32'h00000000);
    // A genuine wrap does raise the overflow flag
    wr(ccpcm_pkg::ADDR_CTRL2, 32'h00000000);
    run_timer(16'hFFF0, 1'b0);
    rd_reg(ccpcm_pkg::ADDR_STAT);
    check(rd, 32'h00000004);
    finish_test();
  end
endmodule : ccpcm_top_tb_top
`default_nettype wire
